/* logic/gpio_b_port.sv */
// port b gpio: direction, latch, pull-ups, analog select, change enables
// assumes pins sampled on MCLK_I; register accesses arrive as plain strobes
`timescale 1ns/1ns
`default_nettype none
`include "gpio_b_cfg.svh"

// Summary of operation
// - direction one disables driver, zero enables
// - data read gives pins, write hits latch
// - data writes merge unchanged bits from pins
// - analog pins read back as zero
// - outputs drive only with direction clear
// - enabled shared function takes the pin
// - small variant bits 0,4,5; large adds 1,6,7
// - per-pin change interrupt enable bits
// - reset clears all change interrupt enables
// - per-pin weak pull-up enable bits
// - outputs force their pull-up off
// - reset leaves global pull-up control disabled
// - analog select reads zero, enables analog
// - analog select leaves digital outputs working
// - merge uses zero from analog outputs
// - analog select bits reset to analog
// - pull-up needs global, input, enable, digital
// - highest-priority output function owns pin
module gpio_b_port #(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input  wire logic                    MCLK_I,
    input  wire logic                    RST_N_I,
    // register writes
    input  wire gpio_b_pkg::port_wr_type DATA_WR_I,
    input  wire gpio_b_pkg::reg_wr_type  DIR_WR_I,
    input  wire gpio_b_pkg::reg_wr_type  PULLUP_WR_I,
    input  wire gpio_b_pkg::reg_wr_type  ANALOG_WR_I,
    input  wire gpio_b_pkg::reg_wr_type  IOC_WR_I,
    input  wire logic                    GLOBAL_WR_I,
    input  wire logic                    GLOBAL_WDATA_I,
    // register read-back
    output logic [7:0]                   PIN_LEVEL_O,
    output logic [7:0]                   LATCH_O,
    output logic [7:0]                   DIR_O,
    output logic [7:0]                   PULLUP_EN_O,
    output logic [7:0]                   ANALOG_SEL_O,
    output logic [7:0]                   IOC_EN_O,
    output logic                         GLOBAL_PU_DIS_O,
    // shared peripheral outputs, one per pin
    input  wire logic [7:0]              ALT_OE_I,
    input  wire logic [7:0]              ALT_OUT_I,
    // pads
    input  wire logic [7:0]              PIN_I,
    output logic [7:0]                   PIN_O,
    output logic [7:0]                   PIN_OE_O,
    output logic [7:0]                   PIN_PULLUP_O,
    output logic [7:0]                   ANALOG_ACTIVE_O
);

    // implemented bits depend on the package variant
    wire  [7:0] impl_mask  = LARGE_PKG ? `IMPL_LARGE_MASK : `IMPL_SMALL_MASK;
    wire  [7:0] ansel_mask = `ANSEL_IMPL_MASK & impl_mask;

    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    logic [7:0] port_b_latch_q;
    logic [7:0] port_b_latch_d;
    logic [7:0] port_b_direction_q;
    logic [7:0] port_b_pullup_enables_q;
    logic [7:0] port_b_analog_select_q;
    logic [7:0] pin_change_irq_enable_q;
    logic       global_pullup_control_q;

    // value software reads back from the data port
    wire  [7:0] port_b_pin_level;
    wire  [7:0] owner_is_alt;
    wire  [7:0] drive_value;
    wire  [7:0] pullup_on;
    wire  [7:0] analog_sel;

    // two-flop synchroniser; only the second stage is looked at
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end else begin
            pin_meta_q <= PIN_I;
            pin_sync_q <= pin_meta_q;
        end
    end

    // bits 7 and 0 have no analog select; masking keeps them digital
    assign analog_sel = port_b_analog_select_q & ansel_mask;

    // analog pins and absent pins read zero
    assign port_b_pin_level = pin_sync_q & ~analog_sel & impl_mask;

    // merge: written bits from data, the rest from the pins, not the latch;
    // an analog output pin thus gets its latch overwritten with zero
    assign port_b_latch_d = ((DATA_WR_I.data & DATA_WR_I.mask)
                          | (port_b_pin_level & ~DATA_WR_I.mask)) & impl_mask;

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            port_b_latch_q <= `LATCH_RST;
        end else if (DATA_WR_I.en) begin
            port_b_latch_q <= port_b_latch_d;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            port_b_direction_q <= `DIR_RST;
        end else if (DIR_WR_I.en) begin
            port_b_direction_q <= DIR_WR_I.data | ~impl_mask;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            port_b_pullup_enables_q <= `PULLUP_RST;
        end else if (PULLUP_WR_I.en) begin
            port_b_pullup_enables_q <= PULLUP_WR_I.data;
        end
    end

    // reset to analog so nothing digital toggles before software says so
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            port_b_analog_select_q <= `ANSEL_RST;
        end else if (ANALOG_WR_I.en) begin
            port_b_analog_select_q <= ANALOG_WR_I.data;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_change_irq_enable_q <= `IOC_RST;
        end else if (IOC_WR_I.en) begin
            pin_change_irq_enable_q <= IOC_WR_I.data;
        end
    end

    // one disables every pull-up; comes up disabled
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            global_pullup_control_q <= `GLOBAL_PU_RST;
        end else if (GLOBAL_WR_I) begin
            global_pullup_control_q <= GLOBAL_WDATA_I;
        end
    end

    // per-pin output ownership and pull-up
    for (genvar i = 0; i < 8; i++) begin : g_pin
        gpio_b_pkg::owner_type owner;

        // the shared function sits above the port latch in priority
        assign owner = ALT_OE_I[i] ? gpio_b_pkg::OWN_ALT
                                   : gpio_b_pkg::OWN_PORT;
        assign owner_is_alt[i] = (owner == gpio_b_pkg::OWN_ALT);
        assign drive_value[i]  = owner_is_alt[i] ? ALT_OUT_I[i]
                                                 : port_b_latch_q[i];
        // analog select plays no part in the output path
        assign PIN_OE_O[i] = impl_mask[i] & ~port_b_direction_q[i];
        assign pullup_on[i] = impl_mask[i]
                            & ~global_pullup_control_q
                            & port_b_direction_q[i]
                            & port_b_pullup_enables_q[i]
                            & ~analog_sel[i];
    end

    // software may leave an analog pin driving; the driver is honoured anyway
    assign PIN_O           = drive_value & PIN_OE_O;
    assign PIN_PULLUP_O    = pullup_on;
    assign ANALOG_ACTIVE_O = analog_sel;

    assign PIN_LEVEL_O     = port_b_pin_level;
    assign LATCH_O         = port_b_latch_q & impl_mask;
    assign DIR_O           = port_b_direction_q & impl_mask;
    assign PULLUP_EN_O     = port_b_pullup_enables_q & impl_mask;
    assign ANALOG_SEL_O    = analog_sel;
    assign IOC_EN_O        = pin_change_irq_enable_q & impl_mask;
    assign GLOBAL_PU_DIS_O = global_pullup_control_q;

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_dir_blocks_driver;
        (PIN_OE_O & DIR_O) == 8'h00;
    endproperty
    a_dir_blocks_driver: assert property (p_dir_blocks_driver)
        else $error("driver enabled on input pin");

    property p_analog_reads_zero;
        ANALOG_WR_I.en |=> ((PIN_LEVEL_O & $past(ANALOG_WR_I.data) & ansel_mask) == 8'h00);
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero)
        else $error("analog pin read nonzero");

    property p_merge_from_pins;
        (DATA_WR_I.en && DATA_WR_I.mask == 8'h00) |=> LATCH_O == $past(port_b_pin_level);
    endproperty
    a_merge_from_pins: assert property (p_merge_from_pins)
        else $error("unchanged bits not taken from pins");

    property p_full_write;
        (DATA_WR_I.en && DATA_WR_I.mask == 8'hFF) |=> LATCH_O == ($past(DATA_WR_I.data) & impl_mask);
    endproperty
    a_full_write: assert property (p_full_write)
        else $error("latch not loaded on write");

    property p_pullup_gating;
        PIN_PULLUP_O != 8'h00 |-> !GLOBAL_PU_DIS_O
            && ((PIN_PULLUP_O & (~DIR_O | ANALOG_SEL_O | ~PULLUP_EN_O)) == 8'h00);
    endproperty
    a_pullup_gating: assert property (p_pullup_gating)
        else $error("pull-up on where it must be off");

    property p_unimplemented_quiet;
        ((PIN_OE_O | PIN_PULLUP_O | PIN_LEVEL_O | IOC_EN_O) & ~impl_mask) == 8'h00;
    endproperty
    a_unimplemented_quiet: assert property (p_unimplemented_quiet)
        else $error("unimplemented bit active");

    property p_alt_owns_pin;
        ((ALT_OE_I & PIN_OE_O & (PIN_O ^ ALT_OUT_I)) == 8'h00)
        && ((~ALT_OE_I & PIN_OE_O & (PIN_O ^ LATCH_O)) == 8'h00);
    endproperty
    a_alt_owns_pin: assert property (p_alt_owns_pin)
        else $error("wrong function owns pin");

    property p_analog_keeps_output;
        (ANALOG_SEL_O != 8'h00) |-> (PIN_OE_O == (~DIR_O & impl_mask));
    endproperty
    a_analog_keeps_output: assert property (p_analog_keeps_output)
        else $error("analog select changed driver");

    property p_ioc_holds;
        !IOC_WR_I.en |=> $stable(IOC_EN_O);
    endproperty
    a_ioc_holds: assert property (p_ioc_holds)
        else $error("change enable moved without write");

    property p_sync_delay;
        (ANALOG_SEL_O == 8'h00) [*3] |-> PIN_LEVEL_O == ($past(PIN_I, 2) & impl_mask);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("pin level not two cycles behind pad");

    // reset values, seen at the first edge after release
    property p_reset_inputs;
        $rose(RST_N_I) |-> (DIR_O == impl_mask) && (PIN_OE_O == 8'h00);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("pins not inputs after reset");

    property p_reset_ioc_clear;
        $rose(RST_N_I) |-> IOC_EN_O == 8'h00;
    endproperty
    a_reset_ioc_clear: assert property (p_reset_ioc_clear)
        else $error("change enables not cleared by reset");

    property p_reset_pullups_off;
        $rose(RST_N_I) |-> GLOBAL_PU_DIS_O && (PIN_PULLUP_O == 8'h00);
    endproperty
    a_reset_pullups_off: assert property (p_reset_pullups_off)
        else $error("pull-ups not disabled after reset");

    property p_reset_analog;
        $rose(RST_N_I) |-> (ANALOG_SEL_O == ansel_mask) && (PIN_LEVEL_O == 8'h00);
    endproperty
    a_reset_analog: assert property (p_reset_analog)
        else $error("analog select not set after reset");

    // each register write shows on read-back one edge later
    property p_dir_write_lands;
        DIR_WR_I.en |=> DIR_O == ($past(DIR_WR_I.data) & impl_mask);
    endproperty
    a_dir_write_lands: assert property (p_dir_write_lands)
        else $error("direction write lost");

    property p_pullup_write_lands;
        PULLUP_WR_I.en |=> PULLUP_EN_O == ($past(PULLUP_WR_I.data) & impl_mask);
    endproperty
    a_pullup_write_lands: assert property (p_pullup_write_lands)
        else $error("pull-up enable write lost");

    property p_ioc_write_lands;
        IOC_WR_I.en |=> IOC_EN_O == ($past(IOC_WR_I.data) & impl_mask);
    endproperty
    a_ioc_write_lands: assert property (p_ioc_write_lands)
        else $error("change enable write lost");

    property p_analog_write_lands;
        ANALOG_WR_I.en |=> ANALOG_SEL_O == ($past(ANALOG_WR_I.data) & ansel_mask);
    endproperty
    a_analog_write_lands: assert property (p_analog_write_lands)
        else $error("analog select write lost");

    property p_global_write_lands;
        GLOBAL_WR_I |=> GLOBAL_PU_DIS_O == $past(GLOBAL_WDATA_I);
    endproperty
    a_global_write_lands: assert property (p_global_write_lands)
        else $error("global pull-up write lost");

    property p_latch_holds;
        !DATA_WR_I.en |=> $stable(LATCH_O);
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("latch moved without write");

    property p_output_no_pullup;
        (PIN_OE_O & PIN_PULLUP_O) == 8'h00;
    endproperty
    a_output_no_pullup: assert property (p_output_no_pullup)
        else $error("pull-up on a driving pin");

    property p_pullup_all_terms;
        PIN_PULLUP_O == (DIR_O & PULLUP_EN_O & ~ANALOG_SEL_O & {8{!GLOBAL_PU_DIS_O}});
    endproperty
    a_pullup_all_terms: assert property (p_pullup_all_terms)
        else $error("pull-up missing where all terms allow it");

    property p_analog_level_zero;
        (PIN_LEVEL_O & ANALOG_SEL_O) == 8'h00;
    endproperty
    a_analog_level_zero: assert property (p_analog_level_zero)
        else $error("analog pin level nonzero");

    property p_analog_active_matches;
        ANALOG_ACTIVE_O == ANALOG_SEL_O;
    endproperty
    a_analog_active_matches: assert property (p_analog_active_matches)
        else $error("analog enable differs from select");

    property p_quiet_without_driver;
        (PIN_O & ~PIN_OE_O) == 8'h00;
    endproperty
    a_quiet_without_driver: assert property (p_quiet_without_driver)
        else $error("pin value without driver");

    property p_alt_needs_direction;
        (ALT_OE_I & ~DIR_O & impl_mask & (PIN_O ^ ALT_OUT_I)) == 8'h00;
    endproperty
    a_alt_needs_direction: assert property (p_alt_needs_direction)
        else $error("shared function not driving output pin");

    property p_unimpl_regs_zero;
        ((LATCH_O | DIR_O | PULLUP_EN_O | ANALOG_SEL_O) & ~impl_mask) == 8'h00;
    endproperty
    a_unimpl_regs_zero: assert property (p_unimpl_regs_zero)
        else $error("unimplemented register bit set");

endmodule // gpio_b_port

`default_nettype wire

/* logic/gpio_b_cfg.svh */
// constants for the port b gpio block: field masks, reset values
// assumes inclusion by bare name from logic/ sources
`ifndef GPIO_B_CFG_SVH
`define GPIO_B_CFG_SVH

// implemented bit positions per package variant
`define IMPL_SMALL_MASK   8'h31
`define IMPL_LARGE_MASK   8'hF3
// analog-select exists only on bits 6..4 and 1
`define ANSEL_IMPL_MASK   8'h72

// reset values
`define DIR_RST           8'hFF
`define PULLUP_RST        8'hFF
`define ANSEL_RST         8'hFF
`define IOC_RST           8'h00
`define LATCH_RST         8'h00
`define GLOBAL_PU_RST     1'h1

// synchroniser depth on pin inputs
`define SYNC_STAGES       2

`endif

/* logic/gpio_b_pkg.sv */
// types shared by the port b gpio block
// assumes nothing outside itself
package gpio_b_pkg;

    // one full-register write
    typedef struct packed {
        logic       en;
        logic [7:0] data;
    } reg_wr_type;

    // data-port write; bits with mask clear are refilled from the pins
    typedef struct packed {
        logic       en;
        logic [7:0] data;
        logic [7:0] mask;
    } port_wr_type;

    // who owns a pin's output value
    typedef enum logic [0:0] {
        OWN_PORT = 1'b0,
        OWN_ALT  = 1'b1
    } owner_type;

endpackage

/* testbench/pin_board_model.sv */
// board side of the port b pads: external drivers, pull-ups, floating lines
// assumes pad outputs of gpio_b_port and the system clock
`timescale 1ns/1ns
`default_nettype none
module pin_board_model (
    // clock
    input  wire logic       clk_i,
    // pad side of the port
    input  wire logic [7:0] pin_val_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [7:0] pull_i,
    // external drivers
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    // resolved pad level
    output logic [7:0]      pad_o
);
    // a released line wanders so a stale level never reads as valid
    logic [7:0] flt_q = 8'h5A;
    always @(posedge clk_i) flt_q <= ~flt_q;
    assign pad_o = (pin_oe_i & pin_val_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                 | (~pin_oe_i & ~ext_en_i & (pull_i | flt_q));
endmodule // pin_board_model
`default_nettype wire

/* testbench/test_gpio_b_port.sv */
// self-checking bench for gpio_b_port, large variant, random configurations
// assumes pin_board_model resolves the pads
`timescale 1ns/1ns
`default_nettype none
module test_gpio_b_port;
    localparam logic [7:0] IMP = 8'hF3;
    localparam logic [7:0] ANA = 8'h72;
    typedef struct { int sel; logic [7:0] exp; logic [7:0] care; } note_type;
    logic                    clk = 1'b0;
    logic                    rst_n = 1'b0;
    gpio_b_pkg::port_wr_type dwr;
    gpio_b_pkg::reg_wr_type  dirw, puw, anw, iocw;
    logic                    gwr, gdat, gdis, g;
    logic [7:0]              lvl, lat, dir, pue, ans, ioc, pin_o, pin_oe, pull, act;
    logic [7:0]              alt_oe, alt_out, pin_i, ext_en, ext_val;
    logic [7:0]              d, p, a, io, l, m, w, ae, oe, pu, care, elvl, epin;
    logic [7:0]              obs [11];
    string                   nm [11] = '{"lvl", "lat", "dir", "pue", "ans", "ioc",
                                         "gdis", "pin", "oe", "pull", "act"};
    note_type                q[$];
    event                    chk;
    int                      n_mismatch = 0;
    int                      total_checks = 0;
    int                      seed = 11064;

    assign obs = '{lvl, lat, dir, pue, ans, ioc, {7'h00, gdis}, pin_o, pin_oe, pull, act};

    gpio_b_port #(.LARGE_PKG(1'b1)) dut (
        .MCLK_I(clk), .RST_N_I(rst_n), .DATA_WR_I(dwr), .DIR_WR_I(dirw),
        .PULLUP_WR_I(puw), .ANALOG_WR_I(anw), .IOC_WR_I(iocw),
        .GLOBAL_WR_I(gwr), .GLOBAL_WDATA_I(gdat), .PIN_LEVEL_O(lvl), .LATCH_O(lat),
        .DIR_O(dir), .PULLUP_EN_O(pue), .ANALOG_SEL_O(ans), .IOC_EN_O(ioc),
        .GLOBAL_PU_DIS_O(gdis), .ALT_OE_I(alt_oe), .ALT_OUT_I(alt_out), .PIN_I(pin_i),
        .PIN_O(pin_o), .PIN_OE_O(pin_oe), .PIN_PULLUP_O(pull), .ANALOG_ACTIVE_O(act));

    pin_board_model board (
        .clk_i(clk), .pin_val_i(pin_o), .pin_oe_i(pin_oe), .pull_i(pull),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pin_i));

    initial forever #5 clk = ~clk;

    task automatic note(int s, logic [7:0] e, logic [7:0] c = 8'hFF);
        q.push_back('{s, e, c});
    endtask

    task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        note_type nt;
        forever begin
            @(chk);
            while (q.size() > 0) begin
                nt = q.pop_front();
                check(nm[nt.sel], obs[nt.sel] & nt.care, nt.exp & nt.care);
            end
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        {dwr, dirw, puw, anw, iocw, gwr, gdat, alt_oe, alt_out, ext_en, ext_val} = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        note(2, IMP);
        note(3, IMP);
        note(4, ANA);
        note(5, 8'h00);
        note(6, 8'h01);
        note(9, 8'h00);
        note(8, 8'h00);
        -> chk;
        for (int k = 0; k < 40; k++) begin
            {d, p, a, io, l} = {$random(seed), 8'($random(seed))};
            {alt_oe, alt_out, ext_en, ext_val} = $random(seed);
            g = 1'($random(seed));
            if (k[0]) begin
                d = d | (a & ANA);
            end
            @(negedge clk);
            // all registers written in one cycle to stress parallel write paths
            {dirw, puw, anw, iocw} = {1'b1, d, 1'b1, p, 1'b1, a, 1'b1, io};
            dwr = '{1'b1, l, 8'hFF};
            {gwr, gdat} = {1'b1, g};
            @(negedge clk);
            {dwr.en, dirw.en, puw.en, anw.en, iocw.en, gwr} = '0;
            repeat (3) @(negedge clk);
            ae = a & ANA;
            oe = ~d & IMP;
            pu = p & d & ~ae & {8{~g}} & IMP;
            epin = ((alt_oe & alt_out) | (~alt_oe & l)) & oe;
            elvl = (epin | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu)) & IMP & ~ae;
            // floating pads are unpredictable, so only settled bits are compared
            care = oe | ext_en | pu | ~(IMP & ~ae);
            note(0, elvl, care);
            note(1, l & IMP);
            note(2, d & IMP);
            note(3, p & IMP);
            note(4, ae);
            note(5, io & IMP);
            note(6, {7'h00, g});
            note(7, epin);
            note(8, oe);
            note(9, pu);
            note(10, ae);
            -> chk;
            {m, w} = 16'($random(seed));
            // half the merges take every bit from the pins
            m = k[1] ? 8'h00 : (m | ~care);
            dwr = '{1'b1, w, m};
            @(negedge clk);
            dwr.en = 1'b0;
            @(negedge clk);
            note(1, ((w & m) | (elvl & ~m)) & IMP, m | care);
            -> chk;
        end
        @(negedge clk);
        wrap_up();
    end
endmodule // test_gpio_b_port
`default_nettype wire
